// ==== rtl/rxcmd_pkg.sv ====
// Purpose: Shared constants for the receive status byte generator
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package rxcmd_pkg;
	// Register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] mask_off = 8'h08;
	localparam logic [7:0] last_off = 8'h0c;
	// Control fields
	localparam int ctrl_en_bit = 0;
	localparam int ctrl_force_bit = 1;
	localparam logic [1:0] ctrl_reset = 2'h1;
	// Status and mask fields
	localparam int ev_sent_bit = 0;
	localparam int ev_line_bit = 1;
	localparam int ev_comp_bit = 2;
	localparam int ev_rx_bit = 3;
	localparam int ev_width = 4;
	localparam logic [3:0] mask_reset = 4'h0;
	// Status byte field positions
	localparam int line_lsb = 0;
	localparam int vbus_lsb = 2;
	localparam int event_lsb = 4;
	localparam int id_bit = 6;
	localparam int alt_bit = 7;
	// Encoded bus voltage
	localparam logic [1:0] vbus_below_end = 2'h0;
	localparam logic [1:0] vbus_above_end = 2'h1;
	localparam logic [1:0] vbus_sess_valid = 2'h2;
	localparam logic [1:0] vbus_valid = 2'h3;
	// Encoded receive events
	localparam logic [1:0] rx_none = 2'h0;
	localparam logic [1:0] rx_active_code = 2'h1;
	localparam logic [1:0] rx_error_code = 2'h3;
	localparam logic [1:0] rx_disconnect = 2'h2;
	typedef enum logic [2:0] {
		st_idle, st_turn_on, st_send, st_rx_start, st_rx, st_turn_off
	} state_type;
endpackage

// ==== rtl/rxcmd_encode.sv ====
// Purpose: Builds the receive status byte from live status
// Assumes: All inputs synchronous to the bus clock
// Notes: Purely combinational
module rxcmd_encode (
	input wire logic dp,
	input wire logic dm,
	input wire logic sess_end,
	input wire logic sess_vld,
	input wire logic vbus_vld,
	input wire logic rx_active,
	input wire logic rx_error,
	input wire logic host_disc,
	input wire logic id_pin,
	input wire logic alt_int,
	output logic [7:0] byte_out
);
	logic [1:0] vbus_code;
	logic [1:0] ev_code;

	always_comb begin
		if (vbus_vld)
			vbus_code = rxcmd_pkg::vbus_valid;
		else if (sess_vld)
			vbus_code = rxcmd_pkg::vbus_sess_valid;
		else if (sess_end)
			vbus_code = rxcmd_pkg::vbus_below_end;
		else
			vbus_code = rxcmd_pkg::vbus_above_end;
		if (host_disc)
			ev_code = rxcmd_pkg::rx_disconnect;
		else if (rx_active && rx_error)
			ev_code = rxcmd_pkg::rx_error_code;
		else if (rx_active)
			ev_code = rxcmd_pkg::rx_active_code;
		else
			ev_code = rxcmd_pkg::rx_none;
		byte_out = 8'h00;
		// Line state, plus line low, minus line high
		byte_out[rxcmd_pkg::line_lsb] = dp;
		byte_out[rxcmd_pkg::line_lsb + 1] = dm;
		byte_out[rxcmd_pkg::vbus_lsb +: 2] = vbus_code;
		byte_out[rxcmd_pkg::event_lsb +: 2] = ev_code;
		byte_out[rxcmd_pkg::id_bit] = id_pin;
		byte_out[rxcmd_pkg::alt_bit] = alt_int;
	end
endmodule

// ==== rtl/change_detect.sv ====
// Purpose: Flags a change of a sampled status vector
// Assumes: Input synchronous to clk
// Notes: Pulse is combinational, one cycle per change
module change_detect #(
	parameter int width = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [width-1:0] cur,
	output logic changed
);
	logic [width-1:0] prev_q;
	logic [width-1:0] prev_d;

	always_comb begin
		prev_d = cur;
		changed = (cur != prev_q);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			prev_q <= '0;
		else
			prev_q <= prev_d;
	end
endmodule

// ==== rtl/rxcmd_gen.sv ====
// Purpose: Decides when to send the receive status byte, and drives it
// Assumes: Status and link pins synchronous to clk
// Notes: Byte shows status sampled one cycle before it is driven
// Summary of operation
// - Status bytes only in synchronous mode and while the device owns the bus.
// - Send a status byte when the line state changes.
// - Send a status byte when a bus voltage or ID comparator changes.
// - During receive every cycle with direction high, next low carries status.
// - At start-up, send status once direction is low and stop is low.
// - On return to synchronous mode, send status once stop is low.
// - Events during transmit wait until stop has dropped.
// - The byte reflects status sampled one cycle before it is driven.
// - Bits one and zero carry the line state.
// - Bits three and two encode bus voltage level.
// - Bits five and four encode receive events.
// - Bit six equals the ID pin level.
// - Bit seven flags a pending unmasked non-USB interrupt.
// - Line state bit zero follows plus line, bit one minus line.
// - Every direction change has one undriven turnaround cycle.
// - Direction and next rising together mark receive start, not status.
module rxcmd_gen (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic sync_mode,
	input wire logic stp,
	input wire logic tx_busy,
	input wire logic rx_active,
	input wire logic rx_error,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic host_disc,
	input wire logic dp,
	input wire logic dm,
	input wire logic sess_end,
	input wire logic sess_vld,
	input wire logic vbus_vld,
	input wire logic id_pin,
	input wire logic alt_int,
	output logic dir,
	output logic nxt,
	output logic [7:0] data_out,
	output logic data_oe
);
	rxcmd_pkg::state_type state_q, state_d;
	logic dir_q, dir_d, nxt_q, nxt_d, oe_q, oe_d;
	logic [7:0] data_q, data_d, rxcmd;
	logic evt_q, evt_d, boot_q, boot_d, exit_q, exit_d;
	logic sync_q, sync_d, req, line_chg, comp_chg, sent;
	logic [1:0] ctrl_q, ctrl_d;
	logic [3:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [7:0] last_q, last_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d, err_q, err_d, irq_q, irq_d;
	logic access, hit;

	////////////////////////////////////////////////////////////////////
	rxcmd_encode u_enc (
		.dp(dp),
		.dm(dm),
		.sess_end(sess_end),
		.sess_vld(sess_vld),
		.vbus_vld(vbus_vld),
		.rx_active(rx_active),
		.rx_error(rx_error),
		.host_disc(host_disc),
		.id_pin(id_pin),
		.alt_int(alt_int),
		.byte_out(rxcmd)
	);

	change_detect #(.width(2)) u_line (
		.clk(clk),
		.resetn(resetn),
		.cur({dm, dp}),
		.changed(line_chg)
	);

	change_detect #(.width(4)) u_comp (
		.clk(clk),
		.resetn(resetn),
		.cur({id_pin, vbus_vld, sess_vld, sess_end}),
		.changed(comp_chg)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		sent = oe_q && dir_q && !nxt_q;
		sync_d = sync_mode;
		// Events merge in one flag, set wins over clear
		evt_d = evt_q;
		boot_d = boot_q;
		exit_d = exit_q;
		if (sent) begin
			evt_d = 1'b0;
			boot_d = 1'b0;
			exit_d = 1'b0;
		end
		if (line_chg || comp_chg)
			evt_d = 1'b1;
		if (sync_mode && !sync_q)
			exit_d = 1'b1;
		// Only in sync mode, never during transmit or stop
		req = sync_mode && ctrl_q[rxcmd_pkg::ctrl_en_bit] && !tx_busy &&
			!stp && (evt_q || exit_q || boot_q ||
			ctrl_q[rxcmd_pkg::ctrl_force_bit]);
		state_d = state_q;
		unique case (state_q)
			rxcmd_pkg::st_idle: begin
				if (sync_mode && rx_active && !tx_busy)
					state_d = rxcmd_pkg::st_rx_start;
				else if (req)
					state_d = rxcmd_pkg::st_turn_on;
			end
			rxcmd_pkg::st_turn_on:
				state_d = rxcmd_pkg::st_send;
			rxcmd_pkg::st_send: begin
				if (rx_active)
					state_d = rxcmd_pkg::st_rx;
				else
					state_d = rxcmd_pkg::st_turn_off;
			end
			rxcmd_pkg::st_rx_start:
				state_d = rxcmd_pkg::st_rx;
			rxcmd_pkg::st_rx: begin
				// End of receive still reported in a byte
				if (!rx_active)
					state_d = rxcmd_pkg::st_send;
			end
			rxcmd_pkg::st_turn_off:
				state_d = rxcmd_pkg::st_idle;
		endcase
		if (!sync_mode)
			state_d = rxcmd_pkg::st_idle;
		// Turnaround states leave the bus undriven
		dir_d = state_d inside {rxcmd_pkg::st_turn_on, rxcmd_pkg::st_send,
			rxcmd_pkg::st_rx_start, rxcmd_pkg::st_rx};
		oe_d = state_d inside {rxcmd_pkg::st_send, rxcmd_pkg::st_rx};
		// Receive start flagged by next with direction
		nxt_d = (state_d == rxcmd_pkg::st_rx_start) ||
			(state_d == rxcmd_pkg::st_rx && rx_valid && rx_active);
		// Status byte whenever next is low and the bus is driven
		data_d = nxt_d ? rx_data : rxcmd;
		if (!oe_d)
			data_d = 8'h00;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= rxcmd_pkg::st_idle;
			dir_q <= 1'b0;
			nxt_q <= 1'b0;
			oe_q <= 1'b0;
			data_q <= 8'h00;
			evt_q <= 1'b0;
			// Start-up byte is owed from reset
			boot_q <= 1'b1;
			exit_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			state_q <= state_d;
			dir_q <= dir_d;
			nxt_q <= nxt_d;
			oe_q <= oe_d;
			data_q <= data_d;
			evt_q <= evt_d;
			boot_q <= boot_d;
			exit_q <= exit_d;
			sync_q <= sync_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Answer in the second access cycle so every output is a flop
	always_comb begin
		access = psel && penable && !ready_q;
		hit = paddr inside {rxcmd_pkg::ctrl_off, rxcmd_pkg::status_off,
			rxcmd_pkg::mask_off, rxcmd_pkg::last_off};
		ev = '0;
		ev[rxcmd_pkg::ev_sent_bit] = sent;
		ev[rxcmd_pkg::ev_line_bit] = line_chg;
		ev[rxcmd_pkg::ev_comp_bit] = comp_chg;
		ev[rxcmd_pkg::ev_rx_bit] = state_q == rxcmd_pkg::st_rx_start;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		stat_d = stat_q;
		last_d = sent ? data_q : last_q;
		rdata_d = rdata_q;
		ready_d = access;
		err_d = access && !hit;
		if (sent && !rx_active)
			ctrl_d[rxcmd_pkg::ctrl_force_bit] = 1'b0;
		if (access && pwrite) begin
			if (paddr == rxcmd_pkg::ctrl_off)
				ctrl_d = pwdata[1:0];
			if (paddr == rxcmd_pkg::mask_off)
				mask_d = pwdata[3:0];
		end
		if (access && !pwrite) begin
			unique case (paddr)
				rxcmd_pkg::ctrl_off: rdata_d = {30'h0, ctrl_q};
				rxcmd_pkg::status_off: rdata_d = {28'h0, stat_q};
				rxcmd_pkg::mask_off: rdata_d = {28'h0, mask_q};
				rxcmd_pkg::last_off: rdata_d = {24'h0, last_q};
				default: rdata_d = 32'h0;
			endcase
			if (paddr == rxcmd_pkg::status_off)
				stat_d = 4'h0;
		end
		// New events win over the read clear
		stat_d = stat_d | ev;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= rxcmd_pkg::ctrl_reset;
			mask_q <= rxcmd_pkg::mask_reset;
			stat_q <= 4'h0;
			last_q <= 8'h00;
			rdata_q <= 32'h0;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			last_q <= last_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			irq_q <= irq_d;
		end
	end

	always_comb begin
		prdata = rdata_q;
		pready = ready_q;
		pslverr = err_q;
		irq = irq_q;
		dir = dir_q;
		nxt = nxt_q;
		data_out = data_q;
		data_oe = oe_q;
	end

	////////////////////////////////////////////////////////////////////
	chk_sync_only: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) |-> $past(sync_mode))
		else $error("bus taken outside sync mode");
	chk_turn_on_gap: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) |-> !oe_q)
		else $error("bus driven in turnaround on take");
	chk_turn_off_gap: assert property (@(posedge clk) disable iff (!resetn)
		$fell(dir_q) |-> !oe_q ##1 !dir_q)
		else $error("no turnaround on release");
	chk_rx_start: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) && nxt_q |-> $past(rx_active) ##1 dir_q)
		else $error("receive start without receive");
	chk_byte_fresh: assert property (@(posedge clk) disable iff (!resetn)
		dir_q && oe_q && !nxt_q |-> data_q == $past(rxcmd))
		else $error("status byte stale");
	chk_tx_hold: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) && !nxt_q |-> !$past(tx_busy) && !$past(stp))
		else $error("status sent during transmit");
	chk_line_event: assert property (@(posedge clk) disable iff (!resetn)
		line_chg && state_q == rxcmd_pkg::st_idle && sync_mode && !req &&
		!tx_busy && !stp && ctrl_q[rxcmd_pkg::ctrl_en_bit] && !rx_active
		|=> ##2 dir_q && oe_q && !nxt_q)
		else $error("line change not reported");
	chk_send_shape: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) && !nxt_q |=> oe_q && !nxt_q)
		else $error("status byte not driven after take");
	chk_merge_clear: assert property (@(posedge clk) disable iff (!resetn)
		sent && !line_chg && !comp_chg |=> !evt_q)
		else $error("pending event survives send");
	chk_rx_status: assert property (@(posedge clk) disable iff (!resetn)
		state_q == rxcmd_pkg::st_rx && !nxt_q |-> oe_q && dir_q)
		else $error("receive gap without status");
	cov_send: cover property (@(posedge clk) disable iff (!resetn)
		$rose(dir_q) && !nxt_q ##1 sent ##1 !dir_q);
	cov_rx: cover property (@(posedge clk) disable iff (!resetn)
		state_q == rxcmd_pkg::st_rx_start ##1 nxt_q ##1 !nxt_q);
	cov_irq: cover property (@(posedge clk) disable iff (!resetn)
		$rose(irq_q));
endmodule

// ==== tb/link_model.sv ====
// Purpose: Link controller model driving stop and transmit busy
// Assumes: Bench holds go_tx high while a transmit should run
// Notes: Never drives data, so the bus stays clean in turnaround
module link_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic go_tx,
	input wire logic dir,
	input wire logic nxt,
	input wire logic data_oe,
	input wire logic [7:0] data_out,
	output logic stp,
	output logic tx_busy,
	output logic latch_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////
	// stop one cycle at transmit end, low otherwise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stp <= 1'b0;
			tx_busy <= 1'b0;
			latch_rd <= 1'b0;
		end else begin
			stp <= tx_busy && !go_tx && !stp;
			tx_busy <= go_tx || (tx_busy && !stp);
			// alt flag asks for a latch read
			latch_rd <= dir && data_oe && !nxt && data_out[7];
		end
	end
endmodule

// ==== tb/rxcmd_gen_bench.sv ====
// Purpose: Self-checking bench for the status byte generator
// Assumes: Status inputs held steady until each byte is seen
// Notes: Expected bytes queued by the driver, popped by the monitor
module rxcmd_gen_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, rx_data, data_out;
	logic [31:0] pwdata, prdata, rd;
	logic sync_mode, stp, tx_busy, rx_active, rx_error, rx_valid, go_tx;
	logic host_disc, dp, dm, sess_end, sess_vld, vbus_vld, id_pin;
	logic alt_int, dir, nxt, data_oe, dir_p, err, latch_rd, alt_p;
	logic [7:0] exp_q[$];
	int miscompares, samples_checked, seed, r, n;
	////////////////////////////////////////////////////////////////////
	rxcmd_gen dut_u (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .sync_mode(sync_mode), .stp(stp),
		.tx_busy(tx_busy), .rx_active(rx_active), .rx_error(rx_error),
		.rx_valid(rx_valid), .rx_data(rx_data), .host_disc(host_disc),
		.dp(dp), .dm(dm), .sess_end(sess_end), .sess_vld(sess_vld),
		.vbus_vld(vbus_vld), .id_pin(id_pin), .alt_int(alt_int),
		.dir(dir), .nxt(nxt), .data_out(data_out), .data_oe(data_oe));
	link_model link_u (.clk(clk), .resetn(resetn), .go_tx(go_tx),
		.dir(dir), .nxt(nxt), .data_oe(data_oe), .data_out(data_out),
		.stp(stp), .tx_busy(tx_busy), .latch_rd(latch_rd));
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] expb();
		logic [1:0] v;
		logic [1:0] x;
		v = vbus_vld ? 2'h3 : sess_vld ? 2'h2 : sess_end ? 2'h0 : 2'h1;
		x = host_disc ? 2'h2 : !rx_active ? 2'h0 : rx_error ? 2'h3 : 2'h1;
		return {alt_int, id_pin, x, v, dm, dp};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] e,
		input string m);
		samples_checked++;
		if (got !== e) begin
			miscompares++;
			$display("unexpected %0t %s got %h exp %h", $time, m, got, e);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never reassigns psel at once
		@(posedge clk);
	endtask
	task automatic push();
		#1 exp_q.push_back(expb());
	endtask
	task automatic drain(input string nm);
		n = 0;
		while (exp_q.size() != 0 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk(exp_q.size(), 0, "byte missing");
		repeat (4) @(posedge clk);
		$display("test %s done", nm);
	endtask
	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (resetn === 1'b1 && dir !== dir_p)
			chk(data_oe, 0, "turnaround");
		if (resetn === 1'b1)
			chk(latch_rd, alt_p, "latch read");
		dir_p <= dir;
		alt_p <= dir === 1'b1 && data_oe === 1'b1 && nxt === 1'b0 &&
			data_out[7] === 1'b1;
		if (dir === 1'b1 && data_oe === 1'b1 && nxt === 1'b0) begin
			if (exp_q.size() == 0)
				chk(1, 0, "extra byte");
			else
				chk(data_out, exp_q.pop_front(), "status byte");
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, rx_active} = '0;
		{rx_error, rx_valid, rx_data, host_disc, dp, dm, go_tx} = '0;
		{sess_end, sess_vld, vbus_vld, id_pin, alt_int, dir_p, alt_p} = '0;
		sync_mode = 1'b1;
		seed = 89;
		exp_q.push_back(expb());
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		drain("startup");
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			dp <= ~dp;
			dm <= r[3];
			sess_end <= r[0];
			sess_vld <= r[1];
			vbus_vld <= r[2] & r[1];
			id_pin <= r[4];
			alt_int <= r[5];
			host_disc <= r[6] & r[7];
			push();
			drain("random");
		end
		// Two events during transmit merge into one late byte
		go_tx <= 1'b1;
		repeat (3) @(posedge clk);
		dp <= ~dp;
		@(posedge clk);
		id_pin <= ~id_pin;
		repeat (10) @(posedge clk);
		go_tx <= 1'b0;
		push();
		drain("hold");
		sync_mode <= 1'b0;
		repeat (2) @(posedge clk);
		dm <= ~dm;
		repeat (8) @(posedge clk);
		sync_mode <= 1'b1;
		push();
		drain("sync");
		host_disc <= 1'b0;
		rx_valid <= 1'b1;
		rx_data <= r[15:8];
		rx_active <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dir !== 1'b1 && n < 20);
		chk(nxt, 1, "receive start");
		rx_error <= 1'b1;
		repeat (2) @(posedge clk);
		rx_valid <= 1'b0;
		push();
		@(posedge clk);
		rx_valid <= 1'b1;
		repeat (2) @(posedge clk);
		rx_active <= 1'b0;
		rx_valid <= 1'b0;
		push();
		drain("receive");
		rx_error <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'hf, "status events");
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0, "status cleared");
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		exp_q.push_back(expb());
		apb(1'b1, 8'h00, 32'h3);
		drain("force");
		chk(irq, 1, "irq set");
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, {24'h0, expb()}, "last byte");
		apb(1'b0, 8'h04, 32'h0);
		repeat (2) @(posedge clk);
		chk(rd, 32'h1, "status after force");
		chk(irq, 1'b0, "irq clear");
		apb(1'b1, 8'h00, 32'h0);
		dp <= ~dp;
		repeat (12) @(posedge clk);
		exp_q.push_back(expb());
		apb(1'b1, 8'h00, 32'h1);
		drain("enable");
		stop_test();
	end
endmodule
